// [include/parallel_port_consts.svh]
`ifndef PARALLEL_PORT_CONSTS_SVH
`define PARALLEL_PORT_CONSTS_SVH

// ----------------------------------------
// port geometry
// ----------------------------------------
`define PORT_WIDTH 8
`define PORT_COUNT 2
`define PORT_A 0
`define PORT_B 1

// ----------------------------------------
// input buffering
// ----------------------------------------
`define IN_FIFO_DEPTH 32

// ----------------------------------------
// reset values
// ----------------------------------------
`define STROBE_IDLE 1'b1
`define LINES_RESET 8'h00
`define VECTOR_RESET 8'h00

`endif

// [include/parallel_port_pkg.sv]
package parallel_port_pkg;

  // ----------------------------------------
  // operating modes, in mode-number order
  // ----------------------------------------
  typedef enum logic [1:0] {
    mode_output,
    mode_input,
    mode_bidir,
    mode_bitctl
  } port_mode_t;

endpackage

// [core/byte_fifo.sv]
`include "parallel_port_consts.svh"

module byte_fifo #(
  parameter int WIDTH = `PORT_WIDTH,
  parameter int DEPTH = `IN_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // filling side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // draining side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic load;

  assign push = in_valid_in && in_ready_out;
  // refill the output register when it is empty or being taken
  assign load = (count != '0) && (!out_valid_out || out_ready_in);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // ----------------------------------------
  // pointers and fill level
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_out <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (load)
      begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      if (push && !load)
      begin
        count <= CW'(count + 1'b1);
        in_ready_out <= (count < CW'(DEPTH - 1));
      end
      else if (load && !push)
      begin
        count <= CW'(count - 1'b1);
        in_ready_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // registered read data
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      out_valid_out <= 1'b0;
      out_data_out <= '0;
    end
    else if (load)
    begin
      out_valid_out <= 1'b1;
      out_data_out <= mem[rd_ptr];
    end
    else if (out_ready_in)
    begin
      out_valid_out <= 1'b0;
    end
  end

endmodule // byte_fifo

// [core/dual_handshake_parallel_port.sv]
// Notes on behaviour
// RULE_01: two independent byte-wide ports, A and B, move data to and from outside.
// RULE_02: each port has its own mode: input, output, bidirectional or bit control. Port B in mode 2 neither transfers nor drives its lines.
// RULE_03: each port drives a ready output when prepared for a transfer.
// RULE_04: the peripheral pulses a port's low-active strobe when a transfer happened.
// RULE_05: port B strobe and ready act like port A's unless A is in mode 2.
// RULE_06: both ports' data lines are three-state two-way pins.
// RULE_07: each port can request an interrupt and supplies its own vector on acknowledge.
// RULE_08: with A in mode 2, B's strobe/ready handle A input; A's pair handles output.
`include "parallel_port_consts.svh"

module dual_handshake_parallel_port (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // configuration
  input wire parallel_port_pkg::port_mode_t mode_a_in,
  input wire parallel_port_pkg::port_mode_t mode_b_in,
  input wire logic [7:0] bit_dir_a_in,
  input wire logic [7:0] bit_dir_b_in,
  input wire logic [1:0] int_enable_in,
  input wire logic [7:0] vector_a_in,
  input wire logic [7:0] vector_b_in,
  // cpu write side
  input wire logic [1:0] cpu_write_in,
  input wire logic [7:0] cpu_write_data_in,
  // cpu read side, one stream per port
  output logic [1:0] cpu_read_valid_out,
  output logic [7:0] cpu_read_data_a_out,
  output logic [7:0] cpu_read_data_b_out,
  input wire logic [1:0] cpu_read_ready_in,
  output logic [7:0] line_level_a_out,
  output logic [7:0] line_level_b_out,
  // interrupt
  output logic int_request_out,
  input wire logic int_ack_in,
  output logic vector_valid_out,
  output logic [7:0] vector_out,
  // port a pins
  input wire logic port_a_strobe_n_in,
  output logic port_a_ready_out,
  input wire logic [7:0] port_a_lines_in,
  output logic [7:0] port_a_lines_out,
  output logic [7:0] port_a_lines_oe_out,
  // port b pins
  input wire logic port_b_strobe_n_in,
  output logic port_b_ready_out,
  input wire logic [7:0] port_b_lines_in,
  output logic [7:0] port_b_lines_out,
  output logic [7:0] port_b_lines_oe_out
);
  import parallel_port_pkg::*;

  port_mode_t mode [`PORT_COUNT];
  logic [`PORT_COUNT-1:0] strobe_pin;
  logic [7:0] lines_pin [`PORT_COUNT];
  logic [7:0] bit_dir [`PORT_COUNT];
  logic [`PORT_COUNT-1:0] strobe;
  logic [`PORT_COUNT-1:0] strobe_rise;
  logic [7:0] lines [`PORT_COUNT];
  logic [`PORT_COUNT-1:0] out_mode;
  logic [`PORT_COUNT-1:0] in_mode;
  logic [`PORT_COUNT-1:0] in_strobe_rise;
  logic [`PORT_COUNT-1:0] out_full;
  logic [7:0] out_data [`PORT_COUNT];
  logic [`PORT_COUNT-1:0] fifo_ready;
  logic [`PORT_COUNT-1:0] push;
  logic [`PORT_COUNT-1:0] out_done;
  logic [`PORT_COUNT-1:0] pending;
  logic [7:0] cpu_read_data [`PORT_COUNT];
  logic [7:0] pin_byte [`PORT_COUNT];
  logic [7:0] pin_enable [`PORT_COUNT];
  logic [7:0] pin_level [`PORT_COUNT];
  logic [`PORT_COUNT-1:0] ready_flag;
  logic [`PORT_COUNT-1:0] next_ready;
  logic a_bidir;

  assign mode[`PORT_A] = mode_a_in;
  assign mode[`PORT_B] = mode_b_in;
  assign strobe_pin = {port_b_strobe_n_in, port_a_strobe_n_in};
  assign lines_pin[`PORT_A] = port_a_lines_in;
  assign lines_pin[`PORT_B] = port_b_lines_in;
  assign bit_dir[`PORT_A] = bit_dir_a_in;
  assign bit_dir[`PORT_B] = bit_dir_b_in;
  assign a_bidir = (mode_a_in == mode_bidir);

  // ----------------------------------------
  // direction roles per port
  // ----------------------------------------
  // port a owns its input path through b's strobe when bidirectional
  assign out_mode[`PORT_A] = (mode_a_in == mode_output) || a_bidir; // RULE_08
  assign in_mode[`PORT_A] = (mode_a_in == mode_input) || a_bidir; // RULE_08
  assign in_strobe_rise[`PORT_A] = a_bidir ? strobe_rise[`PORT_B] : strobe_rise[`PORT_A]; // RULE_08
  // port b loses its handshake pair while a is bidirectional
  assign out_mode[`PORT_B] = (mode_b_in == mode_output) && !a_bidir; // RULE_05
  assign in_mode[`PORT_B] = (mode_b_in == mode_input) && !a_bidir; // RULE_05
  assign in_strobe_rise[`PORT_B] = strobe_rise[`PORT_B]; // RULE_05

  // ----------------------------------------
  // per-port datapath
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < `PORT_COUNT; i++)
    begin : g_port
      logic [2:0] strobe_sync;
      logic [7:0] lines_s1;
      logic [7:0] lines_s2;
      logic [7:0] lines_s3;
      logic strobe_prev;

      // three-stage sampling, level accepted when stages two and three agree
      always_ff @(posedge clock_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          strobe_sync <= {3{`STROBE_IDLE}};
          strobe[i] <= `STROBE_IDLE;
          strobe_prev <= `STROBE_IDLE;
          lines_s1 <= `LINES_RESET;
          lines_s2 <= `LINES_RESET;
          lines_s3 <= `LINES_RESET;
          lines[i] <= `LINES_RESET;
        end
        else
        begin
          strobe_sync <= {strobe_sync[1:0], strobe_pin[i]};
          if (strobe_sync[1] == strobe_sync[2])
          begin
            strobe[i] <= strobe_sync[2];
          end
          strobe_prev <= strobe[i];
          lines_s1 <= lines_pin[i];
          lines_s2 <= lines_s1;
          lines_s3 <= lines_s2;
          lines[i] <= (lines_s2 & lines_s3) | (lines[i] & (lines_s2 ^ lines_s3));
        end
      end

      // end of the peripheral's low strobe pulse
      assign strobe_rise[i] = strobe[i] && !strobe_prev; // RULE_04

      // cpu byte waits here until the peripheral strobes it away
      assign out_done[i] = out_mode[i] && out_full[i] && strobe_rise[i];
      always_ff @(posedge clock_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          out_full[i] <= 1'b0;
          out_data[i] <= `LINES_RESET;
        end
        else
        begin
          if (cpu_write_in[i])
          begin
            out_data[i] <= cpu_write_data_in;
          end
          if (cpu_write_in[i] && out_mode[i])
          begin
            out_full[i] <= 1'b1;
          end
          else if (out_done[i] || !out_mode[i])
          begin
            out_full[i] <= 1'b0;
          end
        end
      end

      // strobed byte enters the input buffer
      assign push[i] = in_mode[i] && in_strobe_rise[i] && fifo_ready[i]; // RULE_01

      byte_fifo #(
        .WIDTH(`PORT_WIDTH),
        .DEPTH(`IN_FIFO_DEPTH)
      ) u_in_fifo (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .in_valid_in(push[i]),
        .in_data_in(lines[i]),
        .in_ready_out(fifo_ready[i]),
        .out_valid_out(cpu_read_valid_out[i]),
        .out_data_out(cpu_read_data[i]),
        .out_ready_in(cpu_read_ready_in[i])
      );

      // pin drive: full byte in mode 0 except port b while a is in mode 2, strobe-gated on port a in mode 2, masked in bit control
      always_ff @(posedge clock_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          pin_byte[i] <= `LINES_RESET;
          pin_enable[i] <= 8'h00;
          pin_level[i] <= `LINES_RESET;
        end
        else
        begin
          pin_byte[i] <= out_data[i]; // RULE_06
          pin_level[i] <= lines[i];
          case (mode[i]) // RULE_02
            mode_output: pin_enable[i] <= out_mode[i] ? 8'hFF : 8'h00;
            mode_bidir: pin_enable[i] <= (i == `PORT_A && !strobe[i]) ? 8'hFF : 8'h00;
            mode_bitctl: pin_enable[i] <= ~bit_dir[i];
            default: pin_enable[i] <= 8'h00;
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // ready outputs
  // ----------------------------------------
  always_comb
  begin
    next_ready[`PORT_A] = 1'b0;
    if (out_mode[`PORT_A])
    begin
      next_ready[`PORT_A] = out_full[`PORT_A]; // RULE_03
    end
    else if (in_mode[`PORT_A])
    begin
      next_ready[`PORT_A] = fifo_ready[`PORT_A]; // RULE_03
    end
    if (a_bidir)
    begin
      next_ready[`PORT_B] = fifo_ready[`PORT_A]; // RULE_08
    end
    else if (out_mode[`PORT_B])
    begin
      next_ready[`PORT_B] = out_full[`PORT_B]; // RULE_05
    end
    else if (in_mode[`PORT_B])
    begin
      next_ready[`PORT_B] = fifo_ready[`PORT_B]; // RULE_05
    end
    else
    begin
      next_ready[`PORT_B] = 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ready_flag <= '0;
    end
    else
    begin
      ready_flag <= next_ready;
    end
  end

  // ----------------------------------------
  // interrupt request and vector
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pending <= '0;
      int_request_out <= 1'b0;
      vector_valid_out <= 1'b0;
      vector_out <= `VECTOR_RESET;
    end
    else
    begin
      // a new event beats the acknowledge clear
      for (int p = 0; p < `PORT_COUNT; p++)
      begin
        if ((push[p] || out_done[p]) && int_enable_in[p])
        begin
          pending[p] <= 1'b1; // RULE_07
        end
        else if (int_ack_in && (p == `PORT_A ? pending[`PORT_A]
                 : (pending[`PORT_B] && !pending[`PORT_A])))
        begin
          pending[p] <= 1'b0;
        end
      end
      int_request_out <= |(pending & int_enable_in); // RULE_07
      vector_valid_out <= int_ack_in && (pending != '0);
      if (int_ack_in && pending[`PORT_A])
      begin
        vector_out <= vector_a_in; // RULE_07
      end
      else if (int_ack_in && pending[`PORT_B])
      begin
        vector_out <= vector_b_in; // RULE_07
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign port_a_ready_out = ready_flag[`PORT_A];
  assign port_b_ready_out = ready_flag[`PORT_B];
  assign port_a_lines_out = pin_byte[`PORT_A];
  assign port_b_lines_out = pin_byte[`PORT_B];
  assign port_a_lines_oe_out = pin_enable[`PORT_A];
  assign port_b_lines_oe_out = pin_enable[`PORT_B];
  assign cpu_read_data_a_out = cpu_read_data[`PORT_A];
  assign cpu_read_data_b_out = cpu_read_data[`PORT_B];
  assign line_level_a_out = pin_level[`PORT_A];
  assign line_level_b_out = pin_level[`PORT_B];

endmodule // dual_handshake_parallel_port

// [testbench/dual_handshake_parallel_port_asserts.sv]
module dual_handshake_parallel_port_asserts (
  // watched ports
  input wire logic clock_in,
  input wire logic rst_in,
  input wire parallel_port_pkg::port_mode_t mode_a_in,
  input wire logic [1:0] cpu_write_in,
  input wire logic [7:0] cpu_write_data_in,
  input wire logic [1:0] int_enable_in,
  input wire logic int_ack_in,
  input wire logic [1:0] cpu_read_ready_in,
  input wire logic port_a_strobe_n_in,
  input wire logic [1:0] cpu_read_valid_out,
  input wire logic [7:0] cpu_read_data_a_out,
  input wire logic [7:0] cpu_read_data_b_out,
  input wire logic int_request_out,
  input wire logic vector_valid_out,
  input wire logic port_a_ready_out,
  input wire logic [7:0] port_a_lines_out,
  input wire logic [7:0] port_a_lines_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import parallel_port_pkg::*;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  ready_after_write_a: assert property (
    cpu_write_in[0] && mode_a_in == mode_output |-> ##2 port_a_ready_out)
    else $error("port a ready missing after write");
  byte_on_lines_a: assert property (
    cpu_write_in[0] && mode_a_in == mode_output
    |-> ##2 port_a_lines_out == $past(cpu_write_data_in, 2))
    else $error("port a byte not on lines");
  drive_lines_a: assert property (
    cpu_write_in[0] && mode_a_in == mode_output |-> ##2 port_a_lines_oe_out == 8'hFF)
    else $error("port a lines not driven");
  ready_drop_a: assert property (
    $rose(port_a_strobe_n_in) && port_a_ready_out && mode_a_in == mode_output
    |-> ##[3:7] !port_a_ready_out)
    else $error("port a ready stays after strobe");
  input_float_a: assert property (
    mode_a_in == mode_input && $past(mode_a_in) == mode_input |-> port_a_lines_oe_out == 8'h00)
    else $error("port a drives in input mode");
  hold_valid_a: assert property (
    cpu_read_valid_out[0] && !cpu_read_ready_in[0]
    |=> cpu_read_valid_out[0] && $stable(cpu_read_data_a_out))
    else $error("port a read byte not held");
  hold_valid_b_a: assert property (
    cpu_read_valid_out[1] && !cpu_read_ready_in[1]
    |=> cpu_read_valid_out[1] && $stable(cpu_read_data_b_out))
    else $error("port b read byte not held");
  vector_reply_a: assert property (
    int_ack_in && int_request_out |=> vector_valid_out)
    else $error("no vector after acknowledge");
  quiet_masked_a: assert property (
    int_enable_in == 2'h0 && $past(int_enable_in) == 2'h0 |-> !int_request_out)
    else $error("request while disabled");
  bidir_release_a: assert property (
    (mode_a_in == mode_bidir && port_a_strobe_n_in) [*8] |-> port_a_lines_oe_out == 8'h00)
    else $error("port a drives without strobe in mode 2");
endmodule // dual_handshake_parallel_port_asserts

bind dual_handshake_parallel_port dual_handshake_parallel_port_asserts
  i_dual_handshake_parallel_port_asserts (.*);

// [testbench/port_peripheral_model.sv]
module port_peripheral_model (
  // handshake pins
  input wire logic clock_in,
  input wire logic ready_in,
  input wire logic [7:0] lines_in,
  output logic strobe_n_out,
  output logic [7:0] lines_out,
  // control and results
  input wire logic accept_in,
  input wire logic [2:0] delay_in,
  output logic [7:0] got_out,
  output int got_count_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    strobe_n_out = 1'b1;
    lines_out = 8'hA5;
    got_out = 8'h00;
    got_count_out = 0;
  end

  // long low strobe, byte sampled late in it
  task automatic pulse();
    strobe_n_out = 1'b0;
    repeat (7) @(negedge clock_in);
    got_out = lines_in;
    @(negedge clock_in);
    strobe_n_out = 1'b1;
  endtask

  task automatic send(input logic [7:0] b);
    @(negedge clock_in);
    lines_out = b;
    @(negedge clock_in);
    pulse();
    repeat (4) @(negedge clock_in);
    lines_out = ~b;
    repeat (6) @(negedge clock_in);
  endtask

  always @(negedge clock_in)
    if (accept_in && ready_in)
    begin
      repeat (delay_in) @(negedge clock_in);
      pulse();
      repeat (8) @(negedge clock_in);
      got_count_out++;
    end
endmodule // port_peripheral_model

// [testbench/test_dual_handshake_parallel_port.sv]
module test_dual_handshake_parallel_port;
  timeunit 1ns;
  timeprecision 1ns;
  import parallel_port_pkg::*;

  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  port_mode_t mode_a, mode_b;
  logic [7:0] dir_a, dir_b, vec_a, vec_b, wdata, rd_a, rd_b, lvl_a, lvl_b, vout, w, r;
  logic [7:0] a_out, a_oe, b_out, b_oe, a_in, b_in, ma_lines, mb_lines, ma_got, mb_got;
  logic [1:0] int_en, wr, rd_ready, rd_valid;
  logic [2:0] dly;
  logic ack, irq, vvalid, a_rdy, b_rdy, ma_strobe_n, mb_strobe_n, acc_a, acc_b;
  int ma_cnt, mb_cnt, fail_count, total_checks;
  logic [7:0] q[$];

  always #20 clock_in = ~clock_in;
  assign a_in = (a_out & a_oe) | ((mode_a == mode_bidir ? mb_lines : ma_lines) & ~a_oe);
  assign b_in = (b_out & b_oe) | (mb_lines & ~b_oe);

  dual_handshake_parallel_port i_dual_handshake_parallel_port (
    .clock_in(clock_in), .rst_in(rst_in), .mode_a_in(mode_a), .mode_b_in(mode_b),
    .bit_dir_a_in(dir_a), .bit_dir_b_in(dir_b), .int_enable_in(int_en),
    .vector_a_in(vec_a), .vector_b_in(vec_b), .cpu_write_in(wr), .cpu_write_data_in(wdata),
    .cpu_read_valid_out(rd_valid), .cpu_read_data_a_out(rd_a), .cpu_read_data_b_out(rd_b),
    .cpu_read_ready_in(rd_ready), .line_level_a_out(lvl_a), .line_level_b_out(lvl_b),
    .int_request_out(irq), .int_ack_in(ack), .vector_valid_out(vvalid), .vector_out(vout),
    .port_a_strobe_n_in(ma_strobe_n), .port_a_ready_out(a_rdy), .port_a_lines_in(a_in),
    .port_a_lines_out(a_out), .port_a_lines_oe_out(a_oe),
    .port_b_strobe_n_in(mb_strobe_n), .port_b_ready_out(b_rdy), .port_b_lines_in(b_in),
    .port_b_lines_out(b_out), .port_b_lines_oe_out(b_oe));

  port_peripheral_model i_port_a_model (.clock_in(clock_in), .ready_in(a_rdy),
    .lines_in(a_in), .strobe_n_out(ma_strobe_n), .lines_out(ma_lines), .accept_in(acc_a),
    .delay_in(dly), .got_out(ma_got), .got_count_out(ma_cnt));
  port_peripheral_model i_port_b_model (.clock_in(clock_in), .ready_in(b_rdy),
    .lines_in(b_in), .strobe_n_out(mb_strobe_n), .lines_out(mb_lines), .accept_in(acc_b),
    .delay_in(dly), .got_out(mb_got), .got_count_out(mb_cnt));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] exp_level(input logic [7:0] d, input logic [7:0] dir);
    return (d & ~dir) | (8'hA5 & dir);
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic write(input int p, input logic [7:0] d);
    @(negedge clock_in);
    wdata = d;
    wr[p] = 1'b1;
    @(negedge clock_in);
    wr = 2'h0;
  endtask

  task automatic out_xfer(input int p, input logic [7:0] d);
    int c, n;
    c = p ? mb_cnt : ma_cnt;
    dly = 3'($urandom);
    write(p, d);
    for (n = 0; n < 300 && (p ? mb_cnt : ma_cnt) == c; n++) @(negedge clock_in);
    check(p ? mb_got : ma_got, d);
  endtask

  task automatic take(input int p, output logic [7:0] d);
    int n;
    // one edge with ready low between takes
    @(negedge clock_in);
    for (n = 0; n < 300 && rd_valid[p] !== 1'b1; n++) @(negedge clock_in);
    check({7'h0, rd_valid[p]}, 8'h01);
    d = p ? rd_b : rd_a;
    rd_ready[p] = 1'b1;
    @(negedge clock_in);
    rd_ready = 2'h0;
  endtask

  task automatic irq_ack(input logic [7:0] v);
    check({7'h0, irq}, 8'h01);
    ack = 1'b1;
    @(negedge clock_in);
    ack = 1'b0;
    check({7'h0, vvalid}, 8'h01);
    check(vout, v);
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    mode_a = mode_input;
    mode_b = mode_input;
    dir_a = 8'h00;
    dir_b = 8'hFF;
    int_en = 2'h0;
    wr = 2'h0;
    wdata = 8'h00;
    rd_ready = 2'h0;
    ack = 1'b0;
    acc_a = 1'b0;
    acc_b = 1'b0;
    dly = 3'h0;
    fail_count = 0;
    total_checks = 0;
    void'($urandom(52));
    vec_a = 8'($urandom);
    vec_b = vec_a ^ 8'h5A;
    repeat (6) @(negedge clock_in);
    rst_in = 1'b0;
    check({2'h0, a_rdy, b_rdy, irq, vvalid, rd_valid}, 8'h00);
    @(negedge clock_in);
    // empty input buffers make both input ports ready
    check({2'h0, a_rdy, b_rdy, irq, vvalid, rd_valid}, 8'h30);
    check(a_oe | b_oe, 8'h00);
    mode_a = mode_bitctl;
    mode_b = mode_bitctl;
    dir_a = 8'($urandom);
    dir_b = 8'($urandom);
    w = 8'($urandom);
    r = 8'($urandom);
    write(0, w);
    write(1, r);
    repeat (8) @(negedge clock_in);
    check(a_oe, ~dir_a);
    check(lvl_a, exp_level(w, dir_a));
    check(b_oe, ~dir_b);
    check(lvl_b, exp_level(r, dir_b));
    mode_a = mode_output;
    mode_b = mode_output;
    int_en = 2'h3;
    // ready must follow the new mode before the peripherals listen
    @(negedge clock_in);
    acc_a = 1'b1;
    acc_b = 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      out_xfer(p, 8'($urandom));
      irq_ack(p ? vec_b : vec_a);
    end
    int_en = 2'h0;
    acc_a = 1'b0;
    acc_b = 1'b0;
    mode_a = mode_input;
    mode_b = mode_input;
    for (int p = 0; p < 2; p++)
    begin
      w = 8'($urandom);
      if (p == 0)
        i_port_a_model.send(w);
      else
        i_port_b_model.send(w);
      take(p, r);
      check(r, w);
    end
    mode_a = mode_bidir;
    mode_b = mode_output;
    @(negedge clock_in);
    acc_a = 1'b1;
    out_xfer(0, 8'($urandom));
    acc_a = 1'b0;
    w = 8'($urandom);
    i_port_b_model.send(w);
    take(0, r);
    check(r, w);
    // fill past capacity, reader stalls while the peripheral sends
    mode_a = mode_input;
    for (int i = 0; i < 34; i++)
    begin
      w = 8'($urandom);
      if (i < 33)
        q.push_back(w);
      i_port_a_model.send(w);
    end
    check({7'h0, a_rdy}, 8'h00);
    foreach (q[i])
    begin
      take(0, r);
      check(r, q[i]);
    end
    repeat (4) @(negedge clock_in);
    check({7'h0, rd_valid[0]}, 8'h00);
    results();
  end

  // cycle budget well above the whole sequence
  initial
  begin
    repeat (20000) @(posedge clock_in);
    fail_count++;
    results();
  end
endmodule // test_dual_handshake_parallel_port
